// >>> include/pwm_evt_map.vh
`ifndef PWM_EVT_MAP_VH
`define PWM_EVT_MAP_VH
`define OFS_EVENT_FLAGS   8'h50
`define OFS_IRQ_ENABLE    8'h54
`define OFS_IRQ_STATUS    8'h58
`define OFS_PIN_OE        8'h5c
`define OFS_DT_INTERVAL   8'h64
`define OFS_DT_CONTROL    8'h70
`define RST_WORD          32'h00000000
`define FLD_CMP_UP_LSB    24
`define FLD_PERIOD_LSB    16
`define FLD_CMP_DOWN_LSB  8
`define FLD_ZERO_LSB      0
`define FLD_DT_EN_LSB     0
`define FLD_DT_DIV_LSB    8
`endif

// >>> verilog/deadtime_pair.v
`timescale 1ns/100ps
// Complementary pair with dead-time counted in divided clock ticks
module deadtime_pair (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       tick,
	input  wire       enable,
	input  wire [7:0] dt_len,
	input  wire       wave_a,
	input  wire       wave_b,
	output reg        out_a,
	output reg        out_b
);
	reg       ref_lvl;
	reg [7:0] count;

	always @(posedge clk) begin
		if (!rst_n) begin
			ref_lvl <= 1'b0;
			count   <= 8'h00;
			out_a   <= 1'b0;
			out_b   <= 1'b0;
		end else if (!enable) begin
			ref_lvl <= wave_a;
			count   <= 8'h00;
			out_a   <= wave_a;
			out_b   <= wave_b;
		end else if (wave_a != ref_lvl) begin
			// Both sides off while the dead band runs
			ref_lvl <= wave_a;
			count   <= dt_len;
			out_a   <= 1'b0;
			out_b   <= 1'b0;
		end else if (count != 8'h00) begin
			if (tick)
				count <= count - 8'h01;
		end else begin
			out_a <= ref_lvl;
			out_b <= ~ref_lvl;
		end
	end
endmodule

// >>> verilog/pwm_event_irq_deadtime.v
`timescale 1ns/100ps
`include "pwm_evt_map.vh"
//Contract
// - A compare match while counting up sets the channel's bit in [31:24] of both flag registers.
// - A period match sets the channel's bit in [23:16] of both flag registers.
// - A compare match while counting down sets the channel's bit in [15:8] of both flag registers.
// - Reaching zero while counting down sets the channel's bit in [7:0] of both flag registers.
// - Writing one to a flag bit clears it and all flags reset to zero.
// - Enable bits [31:24] allow the compare-up interrupt of each channel.
// - Enable bits [23:16] allow the period interrupt of each channel.
// - Enable bits [15:8] allow the compare-down interrupt of each channel.
// - Enable bits [7:0] allow the zero-point interrupt of each channel.
// - A channel reaches its pin only while its output gate bit is one; bits [31:8] are reserved.
// - Each pair takes its dead-time length from its own byte of the interval register.
// - Dead-time counts in units of the pair's channel clock divider period.
// - With its generator enabled a pair runs complementary with dead-time between edges.
module pwm_event_irq_deadtime (
	input  wire        CLOCK,
	input  wire        RSTN,
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [7:0]  PADDR,
	input  wire [31:0] PWDATA,
	output reg  [31:0] PRDATA,
	output reg         PREADY,
	output reg         PSLVERR,
	input  wire [7:0]  CMP_UP_HIT,
	input  wire [7:0]  PERIOD_HIT,
	input  wire [7:0]  CMP_DOWN_HIT,
	input  wire [7:0]  ZERO_HIT,
	input  wire [7:0]  WAVE_IN,
	output reg  [7:0]  PWM_PIN,
	output reg         IRQ
);
	reg  [31:0] event_flags;
	reg  [31:0] irq_enable;
	reg  [31:0] irq_status;
	reg  [7:0]  pin_output_gate;
	reg  [31:0] deadtime_interval;
	reg  [3:0]  deadtime_gen_enable;
	reg  [3:0]  div_sel [0:3];
	reg  [15:0] prescale;
	reg  [31:0] next_event_flags;
	reg  [31:0] next_irq_status;
	reg  [31:0] rd_word;
	wire [31:0] hits;
	wire [7:0]  dt_wave;
	wire        wr;
	wire        rd;
	integer     i;

	// One wait state: read data is loaded on the same edge that raises ready, so it stands with ready
	assign wr = PSEL & PENABLE & PWRITE & PREADY;
	assign rd = PSEL & PENABLE & ~PWRITE & ~PREADY;

	assign hits[`FLD_CMP_UP_LSB+7:`FLD_CMP_UP_LSB]     = CMP_UP_HIT;
	assign hits[`FLD_PERIOD_LSB+7:`FLD_PERIOD_LSB]     = PERIOD_HIT;
	assign hits[`FLD_CMP_DOWN_LSB+7:`FLD_CMP_DOWN_LSB] = CMP_DOWN_HIT;
	assign hits[`FLD_ZERO_LSB+7:`FLD_ZERO_LSB]         = ZERO_HIT;

	function hit_reg;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			hit_reg = (addr == ofs);
		end
	endfunction

	// W1C with set priority
	function [31:0] w1c;
		input [31:0] cur;
		input [31:0] set;
		input        clr_en;
		input [31:0] clr;
		begin
			w1c = (cur & ~(clr_en ? clr : 32'h00000000)) | set;
		end
	endfunction

	always @* begin
		next_event_flags = w1c(event_flags, hits, wr & hit_reg(PADDR, `OFS_EVENT_FLAGS), PWDATA);
		next_irq_status  = w1c(irq_status, hits, wr & hit_reg(PADDR, `OFS_IRQ_STATUS), PWDATA);
	end

	always @* begin
		rd_word = 32'h00000000;
		case (PADDR)
		`OFS_EVENT_FLAGS: rd_word = event_flags;
		`OFS_IRQ_ENABLE:  rd_word = irq_enable;
		`OFS_IRQ_STATUS:  rd_word = irq_status;
		`OFS_PIN_OE:      rd_word = {24'h000000, pin_output_gate};
		`OFS_DT_INTERVAL: rd_word = deadtime_interval;
		`OFS_DT_CONTROL:  rd_word = {16'h0000, div_sel[3], div_sel[2], div_sel[1], div_sel[0]} |
			{28'h0000000, deadtime_gen_enable};
		default:          rd_word = 32'h00000000;
		endcase
	end

	always @(posedge CLOCK) begin
		if (!RSTN) begin
			event_flags         <= `RST_WORD;
			irq_status          <= `RST_WORD;
			irq_enable          <= `RST_WORD;
			pin_output_gate     <= 8'h00;
			deadtime_interval   <= `RST_WORD;
			deadtime_gen_enable <= 4'h0;
			for (i = 0; i < 4; i = i + 1)
				div_sel[i] <= 4'h0;
			PRDATA              <= 32'h00000000;
			PREADY              <= 1'b0;
			PSLVERR             <= 1'b0;
			IRQ                 <= 1'b0;
		end else begin
			PREADY      <= PSEL & PENABLE & ~PREADY;
			PSLVERR     <= 1'b0;
			event_flags <= next_event_flags;
			irq_status  <= next_irq_status;
			IRQ <= |(next_irq_status & (wr && PADDR == `OFS_IRQ_ENABLE ? PWDATA : irq_enable));
			if (rd)
				PRDATA <= rd_word;
			if (wr) begin
				case (PADDR)
				`OFS_IRQ_ENABLE:  irq_enable <= PWDATA;
				`OFS_PIN_OE:      pin_output_gate <= PWDATA[7:0];
				`OFS_DT_INTERVAL: deadtime_interval <= PWDATA;
				`OFS_DT_CONTROL: begin
					deadtime_gen_enable <= PWDATA[3:0];
					for (i = 0; i < 4; i = i + 1)
						div_sel[i] <= PWDATA[`FLD_DT_DIV_LSB + 4*i +: 4];
				end
				default: ;
				endcase
			end
		end
	end

	// Free-running prescaler; tap k gives a pulse every 2^k cycles
	always @(posedge CLOCK) begin
		if (!RSTN)
			prescale <= 16'h0000;
		else
			prescale <= prescale + 16'h0001;
	end

	genvar p;
	generate
		for (p = 0; p < 4; p = p + 1) begin : g_pair
			wire [15:0] low_mask = (16'h0001 << div_sel[p]) - 16'h0001;
			wire        tick     = ((prescale & low_mask) == 16'h0000);
			deadtime_pair u_pair (
				.clk    (CLOCK),
				.rst_n  (RSTN),
				.tick   (tick),
				.enable (deadtime_gen_enable[p]),
				.dt_len (deadtime_interval[8*p +: 8]),
				.wave_a (WAVE_IN[2*p]),
				.wave_b (WAVE_IN[2*p+1]),
				.out_a  (dt_wave[2*p]),
				.out_b  (dt_wave[2*p+1])
			);
		end
	endgenerate

	// Gate sits after the dead band so a disabled pin stays low
	always @(posedge CLOCK) begin
		if (!RSTN)
			PWM_PIN <= 8'h00;
		else
			PWM_PIN <= dt_wave & pin_output_gate;
	end
endmodule

// >>> bench/pwm_evt_props.sv
`timescale 1ns/100ps
module pwm_evt_checker (
	input wire        CLOCK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ,
	input wire [7:0]  PADDR, CMP_UP_HIT, PERIOD_HIT, CMP_DOWN_HIT, ZERO_HIT,
	input wire [31:0] PRDATA
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RSTN);
	wire wr = PSEL & PENABLE & PWRITE & PREADY;
	wire rd = PSEL & PENABLE & !PWRITE;
	wire hit = |{CMP_UP_HIT, PERIOD_HIT, CMP_DOWN_HIT, ZERO_HIT};
	property p_rdy; PSEL && PENABLE && !PREADY |=> PREADY && !PSLVERR; endproperty
	a_rdy: assert property (p_rdy) else $error("bus answer wrong");
	property p_hold; IRQ && !wr |=> IRQ; endproperty
	a_hold: assert property (p_hold) else $error("irq dropped");
	property p_rise; $rose(IRQ) |-> $past(wr) || $past(hit); endproperty
	a_rise: assert property (p_rise) else $error("irq without cause");
	property p_prd; !$stable(PRDATA) |-> $past(rd); endproperty
	a_prd: assert property (p_prd) else $error("read data moved");
	property p_poe; rd && PADDR == 8'h5c |=> PRDATA[31:8] == 24'h000000; endproperty
	a_poe: assert property (p_poe) else $error("gate spare bits");
	property p_gap; rd && PADDR == 8'h60 |=> PRDATA == 32'h00000000; endproperty
	a_gap: assert property (p_gap) else $error("unmapped data");
	property p_up; CMP_UP_HIT != 0 ##1 rd && PADDR == 8'h50
		|=> (PRDATA[31:24] & $past(CMP_UP_HIT, 2)) == $past(CMP_UP_HIT, 2); endproperty
	a_up: assert property (p_up) else $error("up flag lost");
	property p_zero; ZERO_HIT != 0 ##1 rd && PADDR == 8'h58
		|=> (PRDATA[7:0] & $past(ZERO_HIT, 2)) == $past(ZERO_HIT, 2); endproperty
	a_zero: assert property (p_zero) else $error("zero flag lost");
	c_clr: cover property (wr && PADDR == 8'h50);
	c_irq: cover property ($rose(IRQ));
	c_up: cover property (CMP_UP_HIT != 0 ##1 rd && PADDR == 8'h50);
endmodule
bind pwm_event_irq_deadtime pwm_evt_checker i_chk (.*);

// >>> bench/pin_load.sv
`timescale 1ns/100ps
// Switch pair on pins 0/1: both on at once would short the supply
module pin_load (
	input wire       clk,
	input wire       arm,
	input wire [7:0] pin,
	output reg       short
);
	initial short = 1'b0;
	always @(posedge clk) begin
		if (arm & pin[0] & pin[1])
			short <= 1'b1;
	end
endmodule

// >>> bench/tb_pwm_event_irq_deadtime.sv
`timescale 1ns/100ps
module tb_pwm_event_irq_deadtime;
	reg			clk, rstn, psel, pen, pw, arm;
	reg [7:0]	pa, wave;
	reg [31:0]	pd, hv, fl, en, st, oe, dt, r, x;
	wire [31:0]	prd;
	wire [7:0]	pin;
	wire		rdy, err, irq, short;
	integer		num_errors, samples_checked, i, k;
	always #50 clk = ~clk;
	pwm_event_irq_deadtime i_dut (.CLOCK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pw), .PADDR(pa), .PWDATA(pd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err),
		.CMP_UP_HIT(hv[31:24]), .PERIOD_HIT(hv[23:16]), .CMP_DOWN_HIT(hv[15:8]),
		.ZERO_HIT(hv[7:0]), .WAVE_IN(wave), .PWM_PIN(pin), .IRQ(irq));
	pin_load i_load (.clk(clk), .arm(arm), .pin(pin), .short(short));
	task chk(input [31:0] s, input [31:0] e); begin
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %0t got %h want %h", $time, s, e);
		end
	end endtask
	task give_verdict; begin
		$display("compares %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end endtask
	// Hits are held over all three sampled edges of the transfer, so one lands just before a read
	task apb(input w, input [7:0] a, input [31:0] d, input [31:0] h); begin
		@(posedge clk); psel <= 1; pw <= w; pa <= a; pd <= d; hv <= h;
		@(posedge clk); pen <= 1;
		fl = fl | h; st = st | h;
		case (a) 8'h50: x = fl; 8'h54: x = en; 8'h58: x = st;
			8'h5c: x = oe & 32'hff; 8'h64: x = dt; default: x = 0; endcase
		k = 0;
		do begin @(posedge clk); k++; end while (rdy !== 1'b1 && k < 20);
		if (k >= 20) begin num_errors++; give_verdict; end
		r = prd;
		psel <= 0; pen <= 0; hv <= 0;
		if (w) case (a) 8'h50: fl = fl & ~d; 8'h54: en = d; 8'h58: st = st & ~d;
			8'h5c: oe = d; 8'h64: dt = d; endcase
		fl = fl | h; st = st | h;
		@(posedge clk);
		if (!w) chk(r, x);
		chk(irq, |(st & en));
	end endtask
	initial begin
		clk = 0; {rstn, psel, pen, pw, arm, pa, wave, pd, hv, fl, en, st, oe, dt} = 0;
		num_errors = 0; samples_checked = 0; k = $urandom(58);
		repeat (16) @(posedge clk); rstn <= 1;
		for (i = 0; i < 6; i++) apb(0, 8'h50 + 4 * i, 0, 0);
		$display("reset values done");
		for (i = 0; i < 80; i++)
			apb($urandom % 2, 8'h50 + 4 * ($urandom % 6), $urandom, $urandom & $urandom & $urandom);
		$display("flags and interrupt done");
		for (i = 0; i < 4; i++) begin
			apb(1, 8'h5c, $urandom, 0); wave <= $urandom;
			repeat (3) @(posedge clk); chk(pin, wave & oe[7:0]);
		end
		$display("output gate done");
		apb(1, 8'h5c, 32'hff, 0); apb(1, 8'h64, 32'h08, 0); apb(1, 8'h70, 32'h01, 0);
		wave <= 0; arm <= 1; repeat (20) @(posedge clk); wave <= 8'h01;
		repeat (4) @(posedge clk); chk(pin[1:0], 0);
		repeat (20) @(posedge clk); chk(pin[1:0], 2'b01);
		wave <= 0; repeat (24) @(posedge clk); chk(pin[1:0], 2'b10);
		chk(short, 0);
		$display("dead-time done");
		give_verdict;
	end
endmodule
